// ---- design/fxsub_adder.sv ----
// three-term adder with carry and signed overflow out
module fxsub_adder #(
  parameter int WIDTH = 32
) (
  // operands
  input  wire logic [WIDTH-1:0] firstOp,
  input  wire logic [WIDTH-1:0] secondOp,
  input  wire logic             carryIn,
  // results
  output logic      [WIDTH-1:0] sum,
  output logic                  carryOut,
  output logic                  overflow
);

  logic [WIDTH:0] wideSum;
  logic [WIDTH-1:0] invFirst;

  // ---------------------------------------------------------------------------
  // inverse of first operand plus second plus carry in
  // ---------------------------------------------------------------------------
  // [RL10] full-width sum
  assign invFirst = ~firstOp;
  assign wideSum  = {1'b0, invFirst} + {1'b0, secondOp} + {{WIDTH{1'b0}}, carryIn};
  assign sum      = wideSum[WIDTH-1:0];
  // [RL10] carry from top bit
  assign carryOut = wideSum[WIDTH];
  // [RL10] signed overflow: like signs in, other sign out
  assign overflow = (invFirst[WIDTH-1] == secondOp[WIDTH-1]) &&
                    (sum[WIDTH-1] != secondOp[WIDTH-1]);

endmodule

// ---- design/fxsub_pkg.sv ----
// constants and encodings of the fixed-point subtract unit
// ---------------------------------------------------------------------------
// Functional notes
// [RL1] plain subtract: target gets inverse of first source, plus one, plus second
// [RL2] plain subtract never changes the carry flag, in any variant
// [RL3] carrying subtract and its alias: inverse first source, plus one, plus second
// [RL4] carrying and extended subtract always update the carry flag
// [RL5] extended subtract: carry flag plus second source plus inverse first source
// [RL6] overflow-enable set updates overflow and sticky summary overflow, else both kept
// [RL7] record bit set: field 0 gets sign, zero and summary overflow, else kept
// [RL8] every operation has four variants from overflow-enable and record bit
// [RL9] decode primary 31, register fields 6-20, enable bit 21, extended 22-30
// [RL10] 32-bit operands; carry out of top bit; signed overflow of the sum
// ---------------------------------------------------------------------------
package fxsub_pkg;

  // ---------------------------------------------------------------------------
  // datapath widths
  // ---------------------------------------------------------------------------
  localparam int FXS_DATA_W   = 32;
  localparam int FXS_REG_W    = 5;
  localparam int FXS_ADDR_W   = 8;

  // ---------------------------------------------------------------------------
  // instruction word fields, bit 0 is the most significant bit
  // ---------------------------------------------------------------------------
  localparam int FXS_PRIM_MSB = 31;   // primary opcode, bits 0-5
  localparam int FXS_PRIM_LSB = 26;
  localparam int FXS_TGT_LSB  = 21;   // target field, bits 6-10
  localparam int FXS_SRCA_LSB = 16;   // first source field, bits 11-15
  localparam int FXS_SRCB_LSB = 11;   // second source field, bits 16-20
  localparam int FXS_OE_POS   = 10;   // overflow-enable, bit 21
  localparam int FXS_EXT_MSB  = 9;    // extended opcode, bits 22-30
  localparam int FXS_EXT_LSB  = 1;
  localparam int FXS_RC_POS   = 0;    // record bit, bit 31

  localparam logic [5:0] FXS_PRIM_OP    = 6'h1f;   // 31
  localparam logic [8:0] FXS_EXT_PLAIN  = 9'h028;  // 40
  localparam logic [8:0] FXS_EXT_CARRY  = 9'h008;  // 8
  localparam logic [8:0] FXS_EXT_EXTEND = 9'h088;  // 136

  // ---------------------------------------------------------------------------
  // operation kinds, one-hot
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    FXS_OP_NONE   = 4'h1,
    FXS_OP_PLAIN  = 4'h2,
    FXS_OP_CARRY  = 4'h4,
    FXS_OP_EXTEND = 4'h8
  } fxsub_op_t;

  // ---------------------------------------------------------------------------
  // software register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FXS_OFS_CTRL   = 8'h00;
  localparam logic [7:0] FXS_OFS_XFLAGS = 8'h04;
  localparam logic [7:0] FXS_OFS_CR0    = 8'h08;
  localparam logic [7:0] FXS_OFS_STATUS = 8'h0c;
  localparam logic [7:0] FXS_OFS_MASK   = 8'h10;
  localparam logic [7:0] FXS_OFS_COUNT  = 8'h14;
  localparam logic [7:0] FXS_OFS_RESULT = 8'h18;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int FXS_CTRL_EN  = 0;   // unit enable
  localparam int FXS_XF_CA    = 0;   // carry flag
  localparam int FXS_XF_OV    = 1;   // overflow flag
  localparam int FXS_XF_SO    = 2;   // summary overflow
  localparam int FXS_CR_SO    = 0;   // field 0 summary copy
  localparam int FXS_CR_ZERO  = 1;
  localparam int FXS_CR_POS   = 2;
  localparam int FXS_CR_NEG   = 3;
  localparam int FXS_EV_DONE  = 0;   // operation written back
  localparam int FXS_EV_OVF   = 1;   // overflow seen with enable set
  localparam int FXS_EV_REJ   = 2;   // instruction refused
  localparam int FXS_EV_W     = 3;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [0:0] FXS_RST_CTRL   = 1'h1;
  localparam logic [2:0] FXS_RST_XFLAGS = 3'h0;
  localparam logic [3:0] FXS_RST_CR0    = 4'h0;
  localparam logic [2:0] FXS_RST_STATUS = 3'h0;
  localparam logic [2:0] FXS_RST_MASK   = 3'h0;

endpackage

// ---- design/fxsub_unit.sv ----
// fixed-point subtract unit: decode, datapath, flags and software registers
module fxsub_unit
  import fxsub_pkg::*;
#(
  parameter int DATA_W = FXS_DATA_W
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // issue from instruction decode
  input  wire logic              instrValid,
  input  wire logic [31:0]       instrWord,
  input  wire logic [DATA_W-1:0] firstSourceVal,
  input  wire logic [DATA_W-1:0] secondSourceVal,
  // write-back to the general registers
  output logic                   wbValid,
  output logic [FXS_REG_W-1:0]   wbTargetReg,
  output logic [DATA_W-1:0]      wbData,
  output logic                   instrRejected,
  // architected flags
  output logic                   carryFlag,
  output logic                   overflowFlag,
  output logic                   summaryOverflow,
  output logic [3:0]             cr0Field,
  // software register port
  input  wire logic [FXS_ADDR_W-1:0] busAddr,
  input  wire logic [31:0]       busWdata,
  input  wire logic              busWr,
  input  wire logic              busRd,
  output logic [31:0]            busRdata,
  // interrupt
  output logic                   irq
);

  // ---------------------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------------------

  // classify an instruction word into an operation kind
  function automatic fxsub_op_t decodeOp(input logic [31:0] word);
    fxsub_op_t op;
    op = FXS_OP_NONE;
    if (word[FXS_PRIM_MSB:FXS_PRIM_LSB] == FXS_PRIM_OP) begin
      unique case (word[FXS_EXT_MSB:FXS_EXT_LSB])
        FXS_EXT_PLAIN:  op = FXS_OP_PLAIN;
        FXS_EXT_CARRY:  op = FXS_OP_CARRY;
        FXS_EXT_EXTEND: op = FXS_OP_EXTEND;
        default:        op = FXS_OP_NONE;
      endcase
    end
    return op;
  endfunction

  // condition field 0 from a signed result and summary overflow
  function automatic logic [3:0] cmpZero(input logic [DATA_W-1:0] value,
                                          input logic             so);
    logic [3:0] field;
    field              = 4'h0;
    field[FXS_CR_NEG]  = value[DATA_W-1];
    field[FXS_CR_ZERO] = (value == '0);
    field[FXS_CR_POS]  = !value[DATA_W-1] && (value != '0);
    field[FXS_CR_SO]   = so;
    return field;
  endfunction

  // bus write strobe aimed at one offset
  function automatic logic wrHit(input logic                  wr,
                                 input logic [FXS_ADDR_W-1:0] addr,
                                 input logic [FXS_ADDR_W-1:0] ofs);
    return wr && (addr == ofs);
  endfunction

  // ---------------------------------------------------------------------------
  // decode of the issued instruction
  // ---------------------------------------------------------------------------
  fxsub_op_t            issueOp;
  logic                 unitEnable;
  logic                 issueOk;
  logic                 issueBad;
  logic                 oeBit;
  logic                 recordBit;
  logic [FXS_REG_W-1:0] targetReg;

  // [RL9] fields of the issued word
  assign issueOp   = decodeOp(instrWord);
  assign oeBit     = instrWord[FXS_OE_POS];
  assign recordBit = instrWord[FXS_RC_POS];
  assign targetReg = instrWord[FXS_TGT_LSB +: FXS_REG_W];

  // an unknown word, or any word while disabled, is refused
  assign issueOk  = instrValid && unitEnable && (issueOp != FXS_OP_NONE);
  assign issueBad = instrValid && !issueOk;

  // ---------------------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------------------
  logic              addCarryIn;
  logic [DATA_W-1:0] addSum;
  logic              addCarry;
  logic              addOverflow;

  // [RL1] [RL3] plain and carrying add a constant one
  // [RL5] extended adds the current carry flag
  always_comb begin
    addCarryIn = 1'b1;
    unique case (issueOp)
      FXS_OP_PLAIN:  addCarryIn = 1'b1;
      FXS_OP_CARRY:  addCarryIn = 1'b1;
      FXS_OP_EXTEND: addCarryIn = carryFlag;
      FXS_OP_NONE:   addCarryIn = 1'b1;
    endcase
  end

  fxsub_adder #(
    .WIDTH    (DATA_W)
  ) u_adder (
    .firstOp  (firstSourceVal),
    .secondOp (secondSourceVal),
    .carryIn  (addCarryIn),
    .sum      (addSum),
    .carryOut (addCarry),
    .overflow (addOverflow)
  );

  // ---------------------------------------------------------------------------
  // flag updates chosen by operation kind and the two variant bits
  // ---------------------------------------------------------------------------
  logic       hwCarryUpd;
  logic       hwOvUpd;
  logic       hwCrUpd;
  logic       next_summary;
  logic [3:0] hwCrValue;

  // [RL2] plain subtract leaves carry alone
  // [RL4] carrying and extended always write carry
  assign hwCarryUpd = issueOk && (issueOp != FXS_OP_PLAIN);

  // [RL6] overflow pair only with overflow-enable set
  // [RL8] each variant bit acts independently
  assign hwOvUpd = issueOk && oeBit;

  // [RL7] field 0 only with record bit set
  assign hwCrUpd = issueOk && recordBit;

  // [RL6] summary overflow is sticky
  assign next_summary = hwOvUpd ? (summaryOverflow | addOverflow) : summaryOverflow;

  // [RL7] sign, zero and the summary value after this instruction
  assign hwCrValue = cmpZero(addSum, next_summary);

  // ---------------------------------------------------------------------------
  // write-back stage, one cycle after issue
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbValid       <= 1'b0;
      instrRejected <= 1'b0;
    end else begin
      wbValid       <= issueOk;
      instrRejected <= issueBad;
    end
  end

  // result and target held until the next accepted operation
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbTargetReg <= '0;
      wbData      <= '0;
    end else if (issueOk) begin
      wbTargetReg <= targetReg;
      wbData      <= addSum;
    end
  end

  // ---------------------------------------------------------------------------
  // software decode
  // ---------------------------------------------------------------------------
  logic wrCtrl;
  logic wrXflags;
  logic wrCr0;
  logic wrStatus;
  logic wrMask;
  logic wrCount;

  assign wrCtrl   = wrHit(busWr, busAddr, FXS_OFS_CTRL);
  assign wrXflags = wrHit(busWr, busAddr, FXS_OFS_XFLAGS);
  assign wrCr0    = wrHit(busWr, busAddr, FXS_OFS_CR0);
  assign wrStatus = wrHit(busWr, busAddr, FXS_OFS_STATUS);
  assign wrMask   = wrHit(busWr, busAddr, FXS_OFS_MASK);
  assign wrCount  = wrHit(busWr, busAddr, FXS_OFS_COUNT);

  // ---------------------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unitEnable <= FXS_RST_CTRL[0];
    end else if (wrCtrl) begin
      unitEnable <= busWdata[FXS_CTRL_EN];
    end
  end

  // ---------------------------------------------------------------------------
  // exception flags; a flag update by an operation in the same cycle beats a software write
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      carryFlag <= FXS_RST_XFLAGS[FXS_XF_CA];
    end else if (hwCarryUpd) begin
      // [RL4] carry from the addition
      carryFlag <= addCarry;
    end else if (wrXflags) begin
      carryFlag <= busWdata[FXS_XF_CA];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflowFlag    <= FXS_RST_XFLAGS[FXS_XF_OV];
      summaryOverflow <= FXS_RST_XFLAGS[FXS_XF_SO];
    end else if (hwOvUpd) begin
      // [RL6] overflow follows the sum, summary only ever sets
      overflowFlag    <= addOverflow;
      summaryOverflow <= next_summary;
    end else if (wrXflags) begin
      overflowFlag    <= busWdata[FXS_XF_OV];
      summaryOverflow <= busWdata[FXS_XF_SO];
    end
  end

  // ---------------------------------------------------------------------------
  // condition field 0
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cr0Field <= FXS_RST_CR0;
    end else if (hwCrUpd) begin
      // [RL7] compare with zero, copy summary
      cr0Field <= hwCrValue;
    end else if (wrCr0) begin
      cr0Field <= busWdata[3:0];
    end
  end

  // ---------------------------------------------------------------------------
  // event status, mask and interrupt
  // ---------------------------------------------------------------------------
  logic [FXS_EV_W-1:0] evStatus;
  logic [FXS_EV_W-1:0] evMask;
  logic [FXS_EV_W-1:0] evSet;
  logic [FXS_EV_W-1:0] evClr;

  always_comb begin
    evSet              = '0;
    evSet[FXS_EV_DONE] = issueOk;
    evSet[FXS_EV_OVF]  = hwOvUpd && addOverflow;
    evSet[FXS_EV_REJ]  = issueBad;
  end

  assign evClr = wrStatus ? busWdata[FXS_EV_W-1:0] : '0;

  // write one to clear; a new event in the same cycle stays set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evStatus <= FXS_RST_STATUS;
    end else begin
      evStatus <= (evStatus & ~evClr) | evSet;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evMask <= FXS_RST_MASK;
    end else if (wrMask) begin
      evMask <= busWdata[FXS_EV_W-1:0];
    end
  end

  // level output, high while an unmasked event is pending
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((evStatus & ~evClr) | evSet) & (wrMask ? busWdata[FXS_EV_W-1:0] : evMask));
    end
  end

  // ---------------------------------------------------------------------------
  // completed-operation counter, cleared by any write to its own offset
  // ---------------------------------------------------------------------------
  logic [31:0] opCount;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opCount <= '0;
    end else if (wrCount) begin
      opCount <= issueOk ? 32'h1 : 32'h0;
    end else if (issueOk) begin
      opCount <= opCount + 32'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // read path: data stand in the cycle after the strobe only
  // ---------------------------------------------------------------------------
  logic [31:0] readMux;

  always_comb begin
    readMux = '0;
    unique case (busAddr)
      FXS_OFS_CTRL:   readMux[FXS_CTRL_EN] = unitEnable;
      FXS_OFS_XFLAGS: begin
        readMux[FXS_XF_CA] = carryFlag;
        readMux[FXS_XF_OV] = overflowFlag;
        readMux[FXS_XF_SO] = summaryOverflow;
      end
      FXS_OFS_CR0:    readMux[3:0] = cr0Field;
      FXS_OFS_STATUS: readMux[FXS_EV_W-1:0] = evStatus;
      FXS_OFS_MASK:   readMux[FXS_EV_W-1:0] = evMask;
      FXS_OFS_COUNT:  readMux = opCount;
      FXS_OFS_RESULT: readMux[DATA_W-1:0] = wbData;
      default:        readMux = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busRdata <= '0;
    end else if (busRd) begin
      busRdata <= readMux;
    end else begin
      busRdata <= '0;
    end
  end

endmodule

// ---- tb/fxsub_regfile_model.sv ----
// register file model: serves operands, takes write-back
module fxsub_regfile_model
  import fxsub_pkg::*;
(
  // clock
  input wire logic        sys_clk,
  // word being issued
  input wire logic [31:0] instrWord,
  // preload from the bench
  input wire logic        loadEn,
  input wire logic [4:0]  loadIdx,
  input wire logic [31:0] loadVal,
  // write-back from the unit
  input wire logic        wbValid,
  input wire logic [4:0]  wbTargetReg,
  input wire logic [31:0] wbData,
  // operands to the unit
  output logic     [31:0] firstSourceVal,
  output logic     [31:0] secondSourceVal
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] regs [32];
  // operands from the source fields
  assign firstSourceVal  = regs[instrWord[20:16]];
  assign secondSourceVal = regs[instrWord[15:11]];
  // write-back takes priority over preload
  always_ff @(posedge sys_clk) begin
    if (wbValid) begin
      regs[wbTargetReg] <= wbData;
    end else if (loadEn) begin
      regs[loadIdx] <= loadVal;
    end
  end
endmodule

// ---- tb/fxsub_unit_props.sv ----
// assertion checker for the fixed-point subtract unit
module fxsub_unit_props
  import fxsub_pkg::*;
#(
  parameter int DATA_W = FXS_DATA_W
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // issue and bus strobes
  input wire logic              instrValid,
  input wire logic [31:0]       instrWord,
  input wire logic [DATA_W-1:0] firstSourceVal,
  input wire logic [DATA_W-1:0] secondSourceVal,
  input wire logic              busWr,
  // results and flags
  input wire logic              wbValid,
  input wire logic [DATA_W-1:0] wbData,
  input wire logic              instrRejected,
  input wire logic              carryFlag,
  input wire logic              overflowFlag,
  input wire logic              summaryOverflow,
  input wire logic [3:0]        cr0Field
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic            isOp, isPlain, oe, rc, cin, expOv;
  logic [DATA_W:0] nextSum, expSum;
  // field decode of the word on offer
  assign isOp = instrValid && (instrWord[31:26] == FXS_PRIM_OP);
  assign isPlain = instrWord[9:1] == FXS_EXT_PLAIN;
  assign oe = instrWord[FXS_OE_POS];
  assign rc = instrWord[FXS_RC_POS];
  assign cin = (instrWord[9:1] == FXS_EXT_EXTEND) ? carryFlag : 1'b1;
  assign nextSum = {1'b0, ~firstSourceVal} + {1'b0, secondSourceVal} + {{DATA_W{1'b0}}, cin};
  // expected sum and overflow, a cycle late
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      expSum <= '0;
      expOv  <= 1'b0;
    end else begin
      expSum <= nextSum;
      expOv  <= (firstSourceVal[DATA_W-1] != secondSourceVal[DATA_W-1])
        && (nextSum[DATA_W-1] != secondSourceVal[DATA_W-1]);
    end
  end
  a_issue_answer: assert property (instrValid |=> wbValid != instrRejected)
    else $error("issue not answered once");
  a_idle_quiet: assert property (!instrValid |=> !wbValid && !instrRejected)
    else $error("pulse without an issue");
  a_bad_refused: assert property (instrValid && !isOp |=> instrRejected)
    else $error("foreign primary opcode accepted");
  a_result_sum: assert property (isOp |=> !wbValid || wbData == expSum[DATA_W-1:0])
    else $error("result differs from sum");
  a_plain_carry: assert property (isOp && isPlain && !busWr |=> $stable(carryFlag))
    else $error("plain subtract moved the carry");
  a_carry_update: assert property (isOp && !isPlain |=> !wbValid || carryFlag == expSum[DATA_W])
    else $error("carry not taken from the sum");
  a_ov_update: assert property (isOp && oe |=> !wbValid
    || (overflowFlag == expOv && (summaryOverflow || !expOv)))
    else $error("overflow or summary wrong");
  a_ov_kept: assert property (instrValid && !oe && !busWr
    |=> $stable(overflowFlag) && $stable(summaryOverflow))
    else $error("overflow moved with enable clear");
  a_cr0_kept: assert property (instrValid && !rc && !busWr |=> $stable(cr0Field))
    else $error("field 0 moved with record clear");
  a_cr0_sign: assert property (isOp && rc |=> !wbValid || cr0Field ==
    {wbData[DATA_W-1], !wbData[DATA_W-1] && |wbData, ~|wbData, summaryOverflow})
    else $error("field 0 wrong");
  c_all_flags: cover property (isOp && oe && rc ##1 wbValid);
  c_refused: cover property (instrRejected);
  c_overflow: cover property (wbValid && overflowFlag);
endmodule

bind fxsub_unit fxsub_unit_props #(.DATA_W(DATA_W)) uProps (
  .sys_clk(sys_clk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
  .firstSourceVal(firstSourceVal), .secondSourceVal(secondSourceVal), .busWr(busWr),
  .wbValid(wbValid), .wbData(wbData), .instrRejected(instrRejected),
  .carryFlag(carryFlag), .overflowFlag(overflowFlag),
  .summaryOverflow(summaryOverflow), .cr0Field(cr0Field)
);

// ---- tb/tb_fxsub_unit.sv ----
// self-checking bench for the fixed-point subtract unit
module tb_fxsub_unit
  import fxsub_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic        rej;
    logic [31:0] data;
    logic [4:0]  tgt;
    logic [2:0]  xf;
    logic [3:0]  cr;
  } fxsub_exp_t;
  logic sys_clk, rst_n, instrValid, wbValid, instrRejected, irq, mCa, mOv, mSo, mEn;
  logic carryFlag, overflowFlag, summaryOverflow, busWr, busRd, loadEn, rdPend;
  logic [31:0] instrWord, firstSourceVal, secondSourceVal, wbData, busWdata, busRdata, loadVal;
  logic [4:0]  wbTargetReg, loadIdx;
  logic [3:0]  cr0Field, mCr;
  logic [7:0]  busAddr;
  logic [31:0] rf [32];
  logic [8:0]  exts [3] = '{FXS_EXT_PLAIN, FXS_EXT_CARRY, FXS_EXT_EXTEND};
  fxsub_exp_t  expQ [$];
  logic [31:0] rdQ [$];
  int          errorCnt, cmpCount;

  fxsub_unit uut (.sys_clk(sys_clk), .rst_n(rst_n), .instrValid(instrValid),
    .instrWord(instrWord), .firstSourceVal(firstSourceVal),
    .secondSourceVal(secondSourceVal), .wbValid(wbValid), .wbTargetReg(wbTargetReg),
    .wbData(wbData), .instrRejected(instrRejected), .carryFlag(carryFlag),
    .overflowFlag(overflowFlag), .summaryOverflow(summaryOverflow), .cr0Field(cr0Field),
    .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
    .busRdata(busRdata), .irq(irq));
  fxsub_regfile_model partner (.sys_clk(sys_clk), .instrWord(instrWord), .loadEn(loadEn),
    .loadIdx(loadIdx), .loadVal(loadVal), .wbValid(wbValid), .wbTargetReg(wbTargetReg),
    .wbData(wbData), .firstSourceVal(firstSourceVal), .secondSourceVal(secondSourceVal));

  // clock
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, exp);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task testDone();
    $display("comparisons %0d errors %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // note the modelled outcome, then issue it
  task issue(input logic [5:0] pr, input logic [8:0] ext, input logic oe, rc,
             input logic [4:0] t, a, b);
    logic [32:0] s;
    logic        v;
    v = pr == FXS_PRIM_OP && mEn
      && (ext == FXS_EXT_PLAIN || ext == FXS_EXT_CARRY || ext == FXS_EXT_EXTEND);
    s = {1'b0, ~rf[a]} + {1'b0, rf[b]} + {32'h0, (ext == FXS_EXT_EXTEND) ? mCa : 1'b1};
    if (v) begin
      if (ext != FXS_EXT_PLAIN) mCa = s[32];
      if (oe) mOv = (rf[a][31] != rf[b][31]) && (s[31] != rf[b][31]);
      mSo = mSo | mOv;
      if (rc) mCr = {s[31], !s[31] && |s[31:0], ~|s[31:0], mSo};
    end
    expQ.push_back('{!v, s[31:0], t, {mSo, mOv, mCa}, mCr});
    instrValid <= 1'b1;
    instrWord <= {pr, t, a, b, oe, ext, rc};
    @(posedge sys_clk);
  endtask

  task idle();
    instrValid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task bus_wr(input logic [7:0] ad, input logic [31:0] d);
    busAddr <= ad;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge sys_clk);
    busWr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task bus_rd(input logic [7:0] ad, input logic [31:0] x);
    rdQ.push_back(x);
    busAddr <= ad;
    busRd <= 1'b1;
    @(posedge sys_clk);
    busRd <= 1'b0;
    @(posedge sys_clk);
  endtask

  // monitor: oldest note per pulse, read data a cycle on
  always @(posedge sys_clk) begin
    fxsub_exp_t e;
    if (rdPend === 1'b1) chk(busRdata, rdQ.pop_front());
    rdPend = busRd;
    if (wbValid === 1'b1 || instrRejected === 1'b1) begin
      chk({31'h0, expQ.size() > 0}, 32'h1);
      e = expQ.pop_front();
      chk({31'h0, instrRejected}, {31'h0, e.rej});
      if (wbValid === 1'b1) chk(wbData, e.data);
      if (wbValid === 1'b1) chk({27'h0, wbTargetReg}, {27'h0, e.tgt});
      chk({29'h0, summaryOverflow, overflowFlag, carryFlag}, {29'h0, e.xf});
      chk({28'h0, cr0Field}, {28'h0, e.cr});
    end
  end

  // watchdog
  initial begin
    #(5000 * 100);
    errorCnt++;
    testDone();
  end

  // main sequence
  initial begin
    {sys_clk, rst_n, instrValid, instrWord, busAddr, busWdata, busWr, busRd} = '0;
    {loadEn, loadIdx, loadVal, rdPend, mCa, mOv, mSo, mCr} = '0;
    mEn = 1'b1;
    void'($urandom(32'h084406e9));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) rf[i] = $urandom();
    rf[0] = 32'h80007000;
    rf[1] = 32'h90003000;
    rf[2] = 32'h80000000;
    rf[3] = 32'h00004500;
    for (int i = 0; i < 16; i++) begin
      loadEn <= 1'b1;
      loadIdx <= i[4:0];
      loadVal <= rf[i];
      @(posedge sys_clk);
    end
    loadEn <= 1'b0;
    bus_rd(FXS_OFS_CTRL, 32'h1);
    bus_rd(FXS_OFS_XFLAGS, 32'h0);
    bus_rd(FXS_OFS_MASK, 32'h0);
    // fixed vectors: no borrow, signed overflow, zero result
    issue(FXS_PRIM_OP, FXS_EXT_PLAIN, 1'b0, 1'b0, 5'd16, 5'd0, 5'd1);
    issue(FXS_PRIM_OP, FXS_EXT_PLAIN, 1'b1, 1'b1, 5'd17, 5'd2, 5'd3);
    issue(FXS_PRIM_OP, FXS_EXT_CARRY, 1'b0, 1'b1, 5'd18, 5'd4, 5'd4);
    // all operations, all four variants
    for (int k = 0; k < 12; k++) begin
      issue(FXS_PRIM_OP, exts[k / 4], k[1], k[0], 5'd19, 5'd5, 5'd6);
    end
    for (int i = 0; i < 60; i++) begin
      issue(FXS_PRIM_OP, exts[$urandom_range(2)], 1'($urandom()), 1'($urandom()),
        5'($urandom_range(31, 16)), 5'($urandom_range(15)), 5'($urandom_range(15)));
    end
    idle();
    bus_rd(FXS_OFS_XFLAGS, {29'h0, mSo, mOv, mCa});
    bus_rd(FXS_OFS_CR0, {28'h0, mCr});
    bus_rd(FXS_OFS_COUNT, 32'h4b);
    bus_wr(8'h1c, 32'hffffffff);
    bus_rd(8'h1c, 32'h0);
    // refusals: foreign primary or extended code, unit off
    issue(6'h1e, FXS_EXT_PLAIN, 1'b1, 1'b1, 5'd20, 5'd0, 5'd1);
    issue(FXS_PRIM_OP, 9'h0ea, 1'b1, 1'b1, 5'd20, 5'd0, 5'd1);
    idle();
    bus_wr(FXS_OFS_CTRL, 32'h0);
    mEn = 1'b0;
    issue(FXS_PRIM_OP, FXS_EXT_CARRY, 1'b1, 1'b1, 5'd20, 5'd2, 5'd3);
    idle();
    bus_wr(FXS_OFS_CTRL, 32'h1);
    mEn = 1'b1;
    // interrupt: clear, unmask done, raise, mask off, clear again
    bus_wr(FXS_OFS_STATUS, 32'h7);
    bus_rd(FXS_OFS_STATUS, 32'h0);
    bus_wr(FXS_OFS_MASK, 32'h1);
    chk({31'h0, irq}, 32'h0);
    issue(FXS_PRIM_OP, FXS_EXT_PLAIN, 1'b0, 1'b0, 5'd21, 5'd7, 5'd8);
    idle();
    chk({31'h0, irq}, 32'h1);
    bus_rd(FXS_OFS_STATUS, 32'h1);
    bus_rd(FXS_OFS_RESULT, rf[8] - rf[7]);
    bus_wr(FXS_OFS_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus_wr(FXS_OFS_STATUS, 32'h1);
    bus_rd(FXS_OFS_STATUS, 32'h0);
    repeat (4) @(posedge sys_clk);
    testDone();
  end
endmodule
